// File: hdl/somf_pkg.sv
// Constants, register map and state codes for the operating-mode sequencer.
// Assumes a single 200 MHz clock; all times are converted to cycles here.
package somf_pkg;

  typedef enum logic [2:0] {
    SOMF_OFF     = 3'h0,
    SOMF_BOOT    = 3'h1,
    SOMF_HIB     = 3'h2,
    SOMF_STANDBY = 3'h3,
    SOMF_WAKE    = 3'h4,
    SOMF_SLEEP   = 3'h5,
    SOMF_TRIG    = 3'h6
  } somf_state_type;

  localparam int CLK_FREQ_MHZ = 200;

  // Times in microseconds; plain defaults, tune per part
  localparam int BOOT_WAIT_TIME_LOW_US = 1;
  localparam int BOOT_WAIT_TIME_HIGH_US = 2;
  localparam int BOOT_PULSE_WIDTH_LOW_US = 1;
  localparam int HIBERNATE_ENTRY_TIME_US = 10;

  localparam logic [11:0] BOOT_LOW_CYC = 12'(BOOT_WAIT_TIME_LOW_US * CLK_FREQ_MHZ);
  localparam logic [11:0] BOOT_HIGH_CYC = 12'(BOOT_WAIT_TIME_HIGH_US * CLK_FREQ_MHZ);
  localparam logic [11:0] BOOT_PULSE_CYC = 12'(BOOT_PULSE_WIDTH_LOW_US * CLK_FREQ_MHZ);
  localparam logic [11:0] HIB_ENTRY_CYC = 12'(HIBERNATE_ENTRY_TIME_US * CLK_FREQ_MHZ);

  // Register byte addresses
  localparam logic [7:0] CTRL_ADDR = 8'h00;
  localparam logic [7:0] STATUS_ADDR = 8'h04;

  // Control register fields
  localparam int CTRL_ACTIVE_BIT = 0;
  localparam int CTRL_DEEP_SLEEP_BIT = 1;
  localparam int CTRL_IRQB_FUNC_BIT = 2;
  localparam int CTRL_ROUTE_B_BIT = 3;
  localparam int CTRL_PULSE_EN_BIT = 4;
  localparam int CTRL_ASLP_LSB = 8;
  localparam int CTRL_ASLP_W = 8;

  // Status register fields
  localparam int STATUS_BOOT_DONE_BIT = 0;
  localparam int STATUS_STATE_LSB = 4;
  localparam int STATUS_BUS_OPEN_BIT = 8;

  // Reset values of control fields
  localparam logic CTRL_ACTIVE_RST = 1'b0;
  localparam logic CTRL_DEEP_SLEEP_RST = 1'b0;
  localparam logic CTRL_IRQB_FUNC_RST = 1'b0;
  localparam logic CTRL_ROUTE_B_RST = 1'b0;
  localparam logic CTRL_PULSE_EN_RST = 1'b1;
  localparam logic [7:0] CTRL_ASLP_RST = 8'h00;

endpackage

// File: hdl/somf_ctl_if.sv
// Control and event signals between the register slave and the mode sequencer.
// Assumes both ends run on the same clock.
`timescale 1ns/1ps
interface somf_ctl_if;
  import somf_pkg::*;
  logic active;
  logic deep_sleep_enable;
  logic irq_b_function_select;
  logic boot_route_b;
  logic boot_pulse_enable;
  logic [7:0] auto_sleep_count;
  logic set_active;
  logic clr_active;
  logic set_boot_done;
  logic regs_clear;
  logic bus_open;
  somf_state_type state;

  modport regs (
    output active, deep_sleep_enable, irq_b_function_select, boot_route_b,
    output boot_pulse_enable, auto_sleep_count,
    input set_active, clr_active, set_boot_done, regs_clear, bus_open, state
  );
  modport fsm (
    input active, deep_sleep_enable, irq_b_function_select, boot_route_b,
    input boot_pulse_enable, auto_sleep_count,
    output set_active, clr_active, set_boot_done, regs_clear, bus_open, state
  );
endinterface

// File: hdl/somf_apb_regs.sv
// APB slave holding the control and status registers.
// Assumes an APB master on sys_clk; the sequencer drives the event side.
`timescale 1ns/1ps
module somf_apb_regs
  import somf_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic clk_en,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  somf_ctl_if.regs ctl
);
  import somf_pkg::*;

  logic pready_q, pready_d;
  logic pslverr_q, pslverr_d;
  logic [31:0] prdata_q, prdata_d;
  logic active_q, active_d;
  logic deep_q, deep_d;
  logic func_q, func_d;
  logic route_q, route_d;
  logic pen_q, pen_d;
  logic [7:0] aslp_q, aslp_d;
  logic done_q, done_d;
  logic acc, wr, hit_ctrl, hit_stat;

  assign acc = psel & penable & pready_q;
  assign hit_ctrl = paddr == CTRL_ADDR;
  assign hit_stat = paddr == STATUS_ADDR;
  assign wr = acc & pwrite & ctl.bus_open;

  always_comb begin
    pready_d = psel & penable & ~pready_q;
    pslverr_d = pready_d & (~ctl.bus_open | ~(hit_ctrl | hit_stat));
    prdata_d = 32'h0000_0000;
    if (pready_d && !pwrite && ctl.bus_open) begin
      if (hit_ctrl) begin
        prdata_d[CTRL_ACTIVE_BIT] = active_q;
        prdata_d[CTRL_DEEP_SLEEP_BIT] = deep_q;
        prdata_d[CTRL_IRQB_FUNC_BIT] = func_q;
        prdata_d[CTRL_ROUTE_B_BIT] = route_q;
        prdata_d[CTRL_PULSE_EN_BIT] = pen_q;
        prdata_d[CTRL_ASLP_LSB +: CTRL_ASLP_W] = aslp_q;
      end else if (hit_stat) begin
        prdata_d[STATUS_BOOT_DONE_BIT] = done_q;
        prdata_d[STATUS_STATE_LSB +: 3] = ctl.state;
        prdata_d[STATUS_BUS_OPEN_BIT] = ctl.bus_open;
      end
    end
    active_d = active_q;
    deep_d = deep_q;
    func_d = func_q;
    route_d = route_q;
    pen_d = pen_q;
    aslp_d = aslp_q;
    done_d = done_q;
    if (wr && hit_ctrl) begin
      active_d = pwdata[CTRL_ACTIVE_BIT];
      deep_d = pwdata[CTRL_DEEP_SLEEP_BIT];
      func_d = pwdata[CTRL_IRQB_FUNC_BIT];
      route_d = pwdata[CTRL_ROUTE_B_BIT];
      pen_d = pwdata[CTRL_PULSE_EN_BIT];
      aslp_d = pwdata[CTRL_ASLP_LSB +: CTRL_ASLP_W];
    end
    if (wr && hit_stat && pwdata[STATUS_BOOT_DONE_BIT]) begin
      done_d = 1'b0;
    end
    if (ctl.regs_clear) begin
      active_d = CTRL_ACTIVE_RST;
      deep_d = CTRL_DEEP_SLEEP_RST;
      func_d = CTRL_IRQB_FUNC_RST;
      route_d = CTRL_ROUTE_B_RST;
      pen_d = CTRL_PULSE_EN_RST;
      aslp_d = CTRL_ASLP_RST;
      done_d = 1'b0;
    end
    // Hardware events win over software writes
    if (ctl.clr_active) begin
      active_d = 1'b0;
    end
    if (ctl.set_active) begin
      active_d = 1'b1;
    end
    if (ctl.set_boot_done) begin
      done_d = 1'b1;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= 32'h0000_0000;
      active_q <= CTRL_ACTIVE_RST;
      deep_q <= CTRL_DEEP_SLEEP_RST;
      func_q <= CTRL_IRQB_FUNC_RST;
      route_q <= CTRL_ROUTE_B_RST;
      pen_q <= CTRL_PULSE_EN_RST;
      aslp_q <= CTRL_ASLP_RST;
      done_q <= 1'b0;
    end else if (clk_en) begin
      pready_q <= pready_d;
      pslverr_q <= pslverr_d;
      prdata_q <= prdata_d;
      active_q <= active_d;
      deep_q <= deep_d;
      func_q <= func_d;
      route_q <= route_d;
      pen_q <= pen_d;
      aslp_q <= aslp_d;
      done_q <= done_d;
    end
  end

  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign ctl.active = active_q;
  assign ctl.deep_sleep_enable = deep_q;
  assign ctl.irq_b_function_select = func_q;
  assign ctl.boot_route_b = route_q;
  assign ctl.boot_pulse_enable = pen_q;
  assign ctl.auto_sleep_count = aslp_q;
endmodule

// File: hdl/somf_top.sv
// Operating-mode sequencer of an accelerometer, with its APB register slave.
// Assumes all pins synchronous to sys_clk; supply_ok comes from power-on detection.
//
// Summary of operation
// - Boot starts once the supply is good; until then off, bus ignored.
// - Boot loads defaults; register bus unavailable during boot.
// - Strap low: boot done flag set; boot pulse on pin a by default.
// - Strap high: motion defaults loaded; boot pulse only on pin b.
// - Hibernate: only wake detection runs; bus closed; registers discarded.
// - Strap low: any wake pin edge leaves hibernate, boots, then standby.
// - Strap high: motion pin high leaves hibernate and starts boot.
// - Strap high: bus opens only after boot; motion detection then starts.
// - Standby: sensor and analog off, bus available.
// - Wake or sleep: analog powered only when measuring; bus available.
// - Strap low: auto wake/sleep switching when auto sleep count nonzero.
// - Strap high: auto wake/sleep defaults off; host may enable it.
// - Trigger function on, strap low: rising trigger edge starts one measurement.
// - After a triggered measurement, return to trigger wait.
// - Trigger wait keeps the bus answering reads and writes.
// - Strap low: deep sleep enable in standby enters hibernate.
// - Strap high: motion pin low for entry time enters hibernate.
// - Strap high: active set after boot when motion pin high.
// - Registers kept going active to standby.
`timescale 1ns/1ps
module somf_top
  import somf_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic clk_en,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic supply_ok,
  input wire logic boot_strap_select,
  input wire logic chip_select_wake_pin,
  input wire logic motion_detect_pin,
  input wire logic trigger_pin,
  input wire logic activity_detect,
  input wire logic inactivity_detect,
  input wire logic meas_request,
  input wire logic meas_done,
  output logic irq_pin_a,
  output logic irq_pin_b,
  output logic serial_available,
  output logic analog_enable,
  output logic wake_detect_enable,
  output logic meas_start,
  output somf_pkg::somf_state_type mode_state
);
  import somf_pkg::*;

  somf_ctl_if ctl ();

  somf_apb_regs u_regs (
    .sys_clk(sys_clk),
    .rst(rst),
    .clk_en(clk_en),
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .paddr(paddr),
    .pwdata(pwdata),
    .prdata(prdata),
    .pready(pready),
    .pslverr(pslverr),
    .ctl(ctl.regs)
  );

  function automatic logic bus_state(input somf_state_type s);
    return (s == SOMF_STANDBY) || (s == SOMF_WAKE) || (s == SOMF_SLEEP) ||
           (s == SOMF_TRIG);
  endfunction

  function automatic logic [11:0] boot_len(input logic strap);
    return strap ? BOOT_HIGH_CYC : BOOT_LOW_CYC;
  endfunction

  // Saturating, so an idle timer stays at zero
  function automatic logic [11:0] count_down(input logic [11:0] v);
    return (v == 12'h000) ? 12'h000 : v - 12'h001;
  endfunction

  somf_state_type state_q, state_d;
  logic [11:0] cnt_q, cnt_d;
  logic [11:0] mot_q, mot_d;
  logic [11:0] pulse_q, pulse_d;
  logic route_b_q, route_b_d;
  logic strap_q, strap_d;
  logic trig_run_q, trig_run_d;
  logic wake_prev_q, wake_prev_d, trig_prev_q, trig_prev_d;
  logic irq_a_q, irq_a_d, irq_b_q, irq_b_d;
  logic bus_q, bus_d, analog_q, analog_d, wdet_q, wdet_d;
  logic mstart_q, mstart_d;
  logic set_active, clr_active, set_boot_done;
  logic mot_hib, wake_edge, trig_rise, auto_on;

  assign mot_hib = strap_q && (mot_q == HIB_ENTRY_CYC);
  assign wake_edge = chip_select_wake_pin ^ wake_prev_q;
  assign trig_rise = trigger_pin & ~trig_prev_q;
  // count of zero disables; reset default is zero
  assign auto_on = ctl.auto_sleep_count != 8'h00;

  always_comb begin
    state_d = state_q;
    cnt_d = cnt_q;
    strap_d = strap_q;
    route_b_d = route_b_q;
    trig_run_d = trig_run_q;
    pulse_d = count_down(pulse_q);
    mstart_d = 1'b0;
    set_active = 1'b0;
    clr_active = 1'b0;
    set_boot_done = 1'b0;
    mot_d = 12'h000;
    if (strap_q && !motion_detect_pin && bus_state(state_q)) begin
      mot_d = mot_hib ? mot_q : mot_q + 12'h001;
    end
    unique case (state_q)
      SOMF_OFF: begin
        strap_d = boot_strap_select;
        if (supply_ok) begin
          state_d = SOMF_BOOT;
          cnt_d = boot_len(boot_strap_select);
        end
      end
      SOMF_BOOT: begin
        if (cnt_q != 12'h000) begin
          cnt_d = count_down(cnt_q);
        end else begin
          set_boot_done = 1'b1;
          if (ctl.boot_pulse_enable) begin
            pulse_d = BOOT_PULSE_CYC;
          end
          route_b_d = strap_q | ctl.boot_route_b;
          if (strap_q && motion_detect_pin) begin
            state_d = SOMF_WAKE;
            set_active = 1'b1;
          end else begin
            state_d = SOMF_STANDBY;
          end
        end
      end
      SOMF_HIB: begin
        if (!strap_q && wake_edge) begin
          state_d = SOMF_BOOT;
          cnt_d = boot_len(strap_q);
        end else if (strap_q && motion_detect_pin) begin
          state_d = SOMF_BOOT;
          cnt_d = boot_len(strap_q);
        end
      end
      SOMF_STANDBY: begin
        trig_run_d = 1'b0;
        if (mot_hib) begin
          state_d = SOMF_HIB;
        end else if (!strap_q && ctl.deep_sleep_enable) begin
          state_d = SOMF_HIB;
        end else if (ctl.active) begin
          state_d = SOMF_WAKE;
        end else if (!strap_q && ctl.irq_b_function_select) begin
          state_d = SOMF_TRIG;
        end
      end
      SOMF_WAKE, SOMF_SLEEP: begin
        if (mot_hib) begin
          state_d = SOMF_HIB;
          clr_active = 1'b1;
        end else if (trig_run_q) begin
          if (meas_done) begin
            state_d = SOMF_TRIG;
            trig_run_d = 1'b0;
          end
        end else if (!ctl.active) begin
          state_d = SOMF_STANDBY;
        end else if (auto_on && state_q == SOMF_WAKE && inactivity_detect) begin
          state_d = SOMF_SLEEP;
        end else if (state_q == SOMF_SLEEP && (activity_detect || !auto_on)) begin
          state_d = SOMF_WAKE;
        end
      end
      SOMF_TRIG: begin
        if (strap_q || !ctl.irq_b_function_select) begin
          state_d = SOMF_STANDBY;
        end else if (trig_rise) begin
          state_d = SOMF_WAKE;
          trig_run_d = 1'b1;
          mstart_d = 1'b1;
        end
      end
      default: begin
        state_d = SOMF_OFF;
      end
    endcase
    if (!supply_ok) begin
      state_d = SOMF_OFF;
      trig_run_d = 1'b0;
      pulse_d = 12'h000;
    end
    irq_a_d = (pulse_d != 12'h000) && !route_b_d;
    irq_b_d = (pulse_d != 12'h000) && route_b_d;
    bus_d = bus_state(state_d);
    analog_d = ((state_d == SOMF_WAKE) || (state_d == SOMF_SLEEP)) &&
               (meas_request || mstart_d);
    wdet_d = state_d == SOMF_HIB;
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      state_q <= SOMF_OFF;
      cnt_q <= 12'h000;
      mot_q <= 12'h000;
      pulse_q <= 12'h000;
      route_b_q <= 1'b0;
      strap_q <= 1'b0;
      trig_run_q <= 1'b0;
    end else if (clk_en) begin
      state_q <= state_d;
      cnt_q <= cnt_d;
      mot_q <= mot_d;
      pulse_q <= pulse_d;
      route_b_q <= route_b_d;
      strap_q <= strap_d;
      trig_run_q <= trig_run_d;
    end
  end

  // Pin history for edge detection
  always_comb begin
    wake_prev_d = chip_select_wake_pin;
    trig_prev_d = trigger_pin;
  end

  // Idle-high wake pin: no false edge after reset; trigger held high is not an edge
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      wake_prev_q <= 1'b1;
      trig_prev_q <= 1'b1;
    end else if (clk_en) begin
      wake_prev_q <= wake_prev_d;
      trig_prev_q <= trig_prev_d;
    end
  end

  // Output flops, so every pin comes straight from a register
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      irq_a_q <= 1'b0;
      irq_b_q <= 1'b0;
      bus_q <= 1'b0;
      analog_q <= 1'b0;
      wdet_q <= 1'b0;
      mstart_q <= 1'b0;
    end else if (clk_en) begin
      irq_a_q <= irq_a_d;
      irq_b_q <= irq_b_d;
      bus_q <= bus_d;
      analog_q <= analog_d;
      wdet_q <= wdet_d;
      mstart_q <= mstart_d;
    end
  end

  assign ctl.set_active = set_active;
  assign ctl.clr_active = clr_active;
  assign ctl.set_boot_done = set_boot_done;
  // registers held at defaults while unpowered, booting or hibernating; kept otherwise
  assign ctl.regs_clear = (state_q == SOMF_OFF) || (state_q == SOMF_BOOT) ||
                          (state_q == SOMF_HIB);
  assign ctl.bus_open = bus_q;
  assign ctl.state = state_q;

  assign irq_pin_a = irq_a_q;
  assign irq_pin_b = irq_b_q;
  assign serial_available = bus_q;
  assign analog_enable = analog_q;
  assign wake_detect_enable = wdet_q;
  assign meas_start = mstart_q;
  assign mode_state = state_q;
endmodule

// File: testbench/somf_asserts.sv
// Checker for the mode sequencer, sees the top-level ports only.
// Assumes it is bound from the bench; one clock, sync reset.
`timescale 1ns/1ps
module somf_asserts
  import somf_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic clk_en,
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic supply_ok,
  input wire logic boot_strap_select,
  input wire logic trigger_pin,
  input wire logic meas_done,
  input wire logic irq_pin_a,
  input wire logic serial_available,
  input wire logic analog_enable,
  input wire logic wake_detect_enable,
  input wire logic meas_start,
  input somf_pkg::somf_state_type mode_state
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  logic strap_q, strap_d, tw_q, tw_d;
  // Strap only counts as sampled in off
  always_comb begin
    strap_d = (mode_state == SOMF_OFF) ? boot_strap_select : strap_q;
    tw_d = (meas_start | tw_q) & (mode_state == SOMF_WAKE);
  end
  always_ff @(posedge sys_clk) begin
    strap_q <= rst ? 1'b0 : strap_d;
    tw_q <= rst ? 1'b0 : tw_d;
  end
  property p_off_bus;
    mode_state == SOMF_OFF |-> !serial_available && !analog_enable;
  endproperty
  a_off_bus: assert property (p_off_bus) else $error("bus open while off");
  property p_off_boot;
    mode_state == SOMF_OFF && supply_ok && clk_en |=> mode_state == SOMF_BOOT;
  endproperty
  a_off_boot: assert property (p_off_boot) else $error("no boot after supply");
  property p_closed;
    psel && penable && !pready && clk_en && mode_state inside {SOMF_OFF, SOMF_BOOT, SOMF_HIB}
      |=> pready && pslverr;
  endproperty
  a_closed: assert property (p_closed) else $error("closed bus answered");
  property p_hib;
    mode_state == SOMF_HIB |-> wake_detect_enable && !serial_available && !analog_enable;
  endproperty
  a_hib: assert property (p_hib) else $error("hibernate outputs wrong");
  property p_standby;
    mode_state == SOMF_STANDBY |-> serial_available && !analog_enable && !wake_detect_enable;
  endproperty
  a_standby: assert property (p_standby) else $error("standby outputs wrong");
  property p_active_bus;
    mode_state inside {SOMF_WAKE, SOMF_SLEEP, SOMF_TRIG} |-> serial_available;
  endproperty
  a_active_bus: assert property (p_active_bus) else $error("bus closed in active");
  property p_trig_start;
    mode_state == SOMF_TRIG && $rose(trigger_pin) && clk_en && supply_ok && !strap_q
      |=> mode_state == SOMF_WAKE && meas_start && analog_enable;
  endproperty
  a_trig_start: assert property (p_trig_start) else $error("trigger not started");
  property p_one_shot;
    meas_start |=> !meas_start;
  endproperty
  a_one_shot: assert property (p_one_shot) else $error("start pulse too long");
  property p_trig_back;
    (meas_start || tw_q) && mode_state == SOMF_WAKE && meas_done && clk_en && supply_ok
      |=> mode_state == SOMF_TRIG;
  endproperty
  a_trig_back: assert property (p_trig_back) else $error("no return to wait");
  property p_strap_pin;
    strap_q |-> !irq_pin_a;
  endproperty
  a_strap_pin: assert property (p_strap_pin) else $error("pulse on pin a");
  property p_legal;
    mode_state inside {SOMF_OFF, SOMF_BOOT, SOMF_HIB, SOMF_STANDBY, SOMF_WAKE, SOMF_SLEEP,
      SOMF_TRIG};
  endproperty
  a_legal: assert property (p_legal) else $error("illegal state");
endmodule

// File: testbench/somf_host_model.sv
// Host and sensor stub: wake pin, trigger pin, measurement done.
// Assumes the bench asks for events with one-cycle requests.
`timescale 1ns/1ps
module somf_host_model (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic wake_req,
  input wire logic trig_req,
  input wire logic meas_start,
  input wire logic [3:0] dly,
  output logic chip_select_wake_pin,
  output logic trigger_pin,
  output logic meas_done
);
  logic [2:0] tp_q;
  logic [3:0] cnt_q;
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      chip_select_wake_pin <= 1'b1;
      tp_q <= 3'h0;
      cnt_q <= 4'h0;
      trigger_pin <= 1'b0;
      meas_done <= 1'b0;
    end else begin
      if (wake_req)
        chip_select_wake_pin <= !chip_select_wake_pin;
      tp_q <= {tp_q[1:0], trig_req};
      trigger_pin <= trig_req | (|tp_q);
      // Slow or prompt done, per dly
      cnt_q <= meas_start ? dly : (cnt_q != 4'h0 ? cnt_q - 4'h1 : 4'h0);
      meas_done <= (cnt_q == 4'h1);
    end
  end
endmodule

// File: testbench/sensor_operating_mode_fsm_test.sv
// Self-checking bench of the mode sequencer over APB and its pins.
// Assumes the host model drives wake and trigger pins.
`timescale 1ns/1ps
module sensor_operating_mode_fsm_test;
  import somf_pkg::*;
  logic sys_clk, rst, clk_en, psel, penable, pwrite, pready, pslverr, supply_ok;
  logic boot_strap_select, chip_select_wake_pin, motion_detect_pin, trigger_pin;
  logic activity_detect, inactivity_detect, meas_request, meas_done, irq_pin_a, irq_pin_b;
  logic serial_available, analog_enable, wake_detect_enable, meas_start, wake_req, trig_req;
  logic [7:0] paddr, c;
  logic [31:0] pwdata, prdata, seed;
  logic [3:0] dly;
  somf_state_type mode_state;
  logic [65:0] exq[$];
  int err_total, n_tests, bc, ia, ib;
  localparam logic [32:0] REFUSE = {1'b1, 32'h0};
  somf_top u_dut (.sys_clk, .rst, .clk_en, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .supply_ok, .boot_strap_select, .chip_select_wake_pin, .motion_detect_pin,
    .trigger_pin, .activity_detect, .inactivity_detect, .meas_request, .meas_done, .irq_pin_a,
    .irq_pin_b, .serial_available, .analog_enable, .wake_detect_enable, .meas_start, .mode_state);
  somf_host_model u_host (.sys_clk, .rst, .wake_req, .trig_req, .meas_start, .dly,
    .chip_select_wake_pin, .trigger_pin, .meas_done);
  initial begin
    sys_clk = 1'b0;
    forever #2.5 sys_clk = ~sys_clk;
  end
  function automatic logic [31:0] xs(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    xs = s ^ (s << 5);
  endfunction
  function automatic logic [31:0] cw(input logic a, d, f, input logic [7:0] n);
    cw = (32'(a) << CTRL_ACTIVE_BIT) | (32'(d) << CTRL_DEEP_SLEEP_BIT)
      | (32'(f) << CTRL_IRQB_FUNC_BIT) | (32'(n) << CTRL_ASLP_LSB) | (32'h1 << CTRL_PULSE_EN_BIT);
  endfunction
  task check(input logic [32:0] seen, input logic [32:0] exp);
    n_tests++;
    if (seen !== exp) begin
      err_total++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task give_verdict;
    if (err_total == 0 && n_tests > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  // Note the expectation, then run one APB transfer
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [65:0] e);
    exq.push_back(e);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    // Only the watchdog ends a wait for the answer
    do begin
      @(posedge sys_clk);
    end while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
    // Idle edge, so a following call never reassigns psel in this step
    @(posedge sys_clk);
  endtask
  task rd(input logic [7:0] a, input logic [32:0] e);
    apb(1'b0, a, 32'h0, {e, 33'h1_ffff_ffff});
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d, {33'h0, 33'h1_0000_0000});
  endtask
  task wait_st(input somf_state_type s, input int m);
    int n;
    n = 0;
    while (mode_state !== s && n < m) begin
      @(posedge sys_clk);
      n++;
    end
    check(33'(mode_state), 33'(s));
  endtask
  task boot(input logic s, input somf_state_type f, input int cyc);
    int b0, a0, z0;
    b0 = bc;
    a0 = ia;
    z0 = ib;
    wait_st(SOMF_BOOT, 5);
    rd(CTRL_ADDR, REFUSE);
    wait_st(f, 3000);
    repeat (250) @(posedge sys_clk);
    check(33'(bc - b0), 33'(cyc + 1));
    check(33'(s ? ib - z0 : ia - a0), 33'(BOOT_PULSE_CYC));
    check(33'(s ? ia - a0 : ib - z0), 33'h0);
  endtask
  // Result watcher: one queued note per completed transfer
  always @(posedge sys_clk) begin
    logic [65:0] en;
    bc <= bc + int'(mode_state == SOMF_BOOT);
    ia <= ia + int'(irq_pin_a);
    ib <= ib + int'(irq_pin_b);
    if (psel && penable && pready === 1'b1) begin
      en = exq.pop_front();
      check({pslverr, prdata} & en[32:0], en[65:33]);
    end
  end
  initial begin
    repeat (20000) @(posedge sys_clk);
    err_total++;
    give_verdict;
  end
  initial begin
    {psel, penable, pwrite, paddr, pwdata, supply_ok, boot_strap_select} = '0;
    {motion_detect_pin, activity_detect, inactivity_detect, meas_request} = '0;
    {wake_req, trig_req, err_total, n_tests, bc, ia, ib} = '0;
    dly = 4'h2;
    clk_en = 1'b1;
    rst = 1'b1;
    seed = 32'd64;
    repeat (4) @(posedge sys_clk);
    rst <= 1'b0;
    rd(CTRL_ADDR, REFUSE);
    supply_ok <= 1'b1;
    boot(1'b0, SOMF_STANDBY, BOOT_LOW_CYC);
    rd(STATUS_ADDR, 33'h131);
    rd(CTRL_ADDR, {1'b0, cw(0, 0, 0, 8'h0)});
    rd(8'h08, REFUSE);
    seed = xs(seed);
    c = seed[7:0] | 8'h01;
    wr(CTRL_ADDR, cw(1, 0, 0, c));
    wait_st(SOMF_WAKE, 10);
    meas_request <= 1'b1;
    repeat (3) @(posedge sys_clk);
    check(33'(analog_enable), 33'h1);
    meas_request <= 1'b0;
    repeat (3) @(posedge sys_clk);
    check(33'(analog_enable), 33'h0);
    inactivity_detect <= 1'b1;
    clk_en <= 1'b0;
    repeat (4) @(posedge sys_clk);
    check(33'(mode_state), 33'(SOMF_WAKE));
    clk_en <= 1'b1;
    wait_st(SOMF_SLEEP, 10);
    inactivity_detect <= 1'b0;
    activity_detect <= 1'b1;
    wait_st(SOMF_WAKE, 10);
    activity_detect <= 1'b0;
    wr(CTRL_ADDR, cw(0, 0, 0, c));
    wait_st(SOMF_STANDBY, 10);
    rd(CTRL_ADDR, {1'b0, cw(0, 0, 0, c)});
    wr(CTRL_ADDR, cw(0, 0, 1, c));
    wait_st(SOMF_TRIG, 10);
    rd(CTRL_ADDR, {1'b0, cw(0, 0, 1, c)});
    for (int i = 0; i < 2; i++) begin
      dly <= i ? 4'h9 : 4'h1;
      trig_req <= 1'b1;
      @(posedge sys_clk);
      trig_req <= 1'b0;
      wait_st(SOMF_WAKE, 10);
      wait_st(SOMF_TRIG, 30);
    end
    wr(CTRL_ADDR, cw(0, 0, 0, c));
    wait_st(SOMF_STANDBY, 10);
    wr(CTRL_ADDR, cw(0, 1, 0, c));
    wait_st(SOMF_HIB, 10);
    rd(CTRL_ADDR, REFUSE);
    wake_req <= 1'b1;
    @(posedge sys_clk);
    wake_req <= 1'b0;
    boot(1'b0, SOMF_STANDBY, BOOT_LOW_CYC);
    rd(CTRL_ADDR, {1'b0, cw(0, 0, 0, 8'h0)});
    supply_ok <= 1'b0;
    wait_st(SOMF_OFF, 5);
    // host leaves trigger select at zero
    boot_strap_select <= 1'b1;
    motion_detect_pin <= 1'b1;
    supply_ok <= 1'b1;
    boot(1'b1, SOMF_WAKE, BOOT_HIGH_CYC);
    rd(CTRL_ADDR, {1'b0, cw(1, 0, 0, 8'h0)});
    motion_detect_pin <= 1'b0;
    wait_st(SOMF_HIB, HIB_ENTRY_CYC + 10);
    motion_detect_pin <= 1'b1;
    boot(1'b1, SOMF_WAKE, BOOT_HIGH_CYC);
    give_verdict;
  end
endmodule
bind somf_top somf_asserts u_chk (.sys_clk, .rst, .clk_en, .psel, .penable, .pready, .pslverr,
  .supply_ok, .boot_strap_select, .trigger_pin, .meas_done, .irq_pin_a, .serial_available,
  .analog_enable, .wake_detect_enable, .meas_start, .mode_state);
